// >>> hw/crs_regs.svh
// register offsets, field positions and timing counts of the synchronizer
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CRS_OFF_CTRL 8'h00
`define CRS_OFF_STATUS 8'h04
`define CRS_OFF_READ_REQUEST_TRIGGER 8'h08
`define CRS_OFF_CFG 8'h0c
`define CRS_OFF_CNT 8'h10
`define CRS_OFF_SCRATCH 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define CRS_CTRL_SOFT_RESET_BIT 0
`define CRS_CTRL_ENABLE 1
`define CRS_STAT_BUSY 7
`define CRS_READ_REQUEST_TRIGGER_ADDR_HI 7
`define CRS_READ_REQUEST_TRIGGER_CONT 14
`define CRS_READ_REQUEST_TRIGGER_TRIG 15

// ----------------------------------------
// timing
// ----------------------------------------
`define CRS_SYNC_CORE_EDGES 6

`endif

// >>> hw/crs_pkg.sv
// types shared by the synchronizer modules
package crs_pkg;

   // ----------------------------------------
   // engine states, one-hot
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_WSYNC = 4'h2,
      ST_RSYNC = 4'h4,
      ST_CONT  = 4'h8
   } crs_state_t;

   // ----------------------------------------
   // kind of write synchronization
   // ----------------------------------------
   typedef enum logic [1:0] {
      WK_CFG    = 2'h0,
      WK_ENABLE = 2'h1,
      WK_SOFT_RESET_BIT  = 2'h2,
      WK_READ_REQUEST_TRIGGER   = 2'h3
   } crs_wkind_t;

endpackage

// >>> hw/crs_edge_sync.sv
// three-flop synchronizer with agreed level and rise pulse
module crs_edge_sync (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic asyncIn,
   output logic level,
   output logic rise
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   logic rise_r;

   // ----------------------------------------
   // synchronizer chain
   // ----------------------------------------
   // first flop feeds only the second
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= asyncIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // level moves only when stages two and three agree
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         level_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         if (s2_r == s3_r) begin
            level_r <= s3_r;
         end
         rise_r <= (s2_r && s3_r && !level_r);
      end
   end

   assign level = level_r;
   assign rise = rise_r;
endmodule

// >>> hw/crs_sync_delay.sv
// counts core clock rises from a start to a done pulse
`include "crs_regs.svh"

module crs_sync_delay #(
   parameter int EDGES = `CRS_SYNC_CORE_EDGES
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic coreRise,
   output logic done,
   output logic running
);
   localparam int CW = $clog2(EDGES + 1);
   localparam logic [CW-1:0] LAST = CW'(EDGES - 1);

   logic [CW-1:0] cnt_r;
   logic run_r;
   logic done_r;

   // ----------------------------------------
   // edge counter; a start restarts the count
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            cnt_r <= '0;
            run_r <= 1'b1;
         end else if (run_r && coreRise) begin
            cnt_r <= cnt_r + CW'(1);
            if (cnt_r == LAST) begin
               run_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   assign done = done_r;
   assign running = run_r;
endmodule

// >>> hw/crs_top.sv
// common register synchronizer between bus side and core clock side
//
// Contract
// - every core transfer is synchronized, whatever the core clock source
// - one shared engine and one busy flag serve all core registers
// - core write starts sync, raises busy, clears it once crossed
// - core write during write sync stalls until the sync finishes
// - read of register being synced or read-synced register stalls
// - settled core registers and bus registers read unstalled during sync
// - read-synced read stalls at once and leaves busy clear
// - such read under busy stalls for the pending sync, then its own
// - master polls busy or issues next access, started after completion
// - writing trigger starts read sync of addressed register, sets busy
// - after basic request busy clears, value served until next write sync
// - continuous control resyncs repeatedly; reads never stall
// - continuous mode sets busy only for the first sync
// - any new sync stops continuous reading; master must restart it
// - continuous sync pauses while the core clock stands still
// - enable write starts sync, sets busy, reads back new value at once
// - during enable sync writes and read-synced reads stall
// - sync-done event excludes enable and soft reset completions
// - soft reset 1 starts sync, reads 1; hardware clears bit and busy
// - during soft reset writes and read-synced reads stall
// - sync lasts over 5 core plus 2 bus periods, under 6 plus 3
// - unsynchronized access is answered within two bus periods
//
// Chosen here: the address-and-strobe port and the register addresses.
`include "crs_regs.svh"

module crs_top #(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 8
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic genericCoreClk,
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic [DATA_W-1:0] busWrData,
   input wire logic busWr,
   input wire logic busRd,
   output logic [DATA_W-1:0] busRdData,
   output logic busRdValid,
   output logic busStall,
   output logic coreEnable,
   output logic [DATA_W-1:0] coreCfg,
   output logic syncDone,
   output crs_pkg::crs_state_t syncState
);
   import crs_pkg::*;

   crs_state_t state_r;
   crs_wkind_t wkind_r;
   logic busy_r;
   logic enable_r;
   logic coreEnable_r;
   logic soft_reset_bit_r;
   logic [DATA_W-1:0] cfgShadow_r;
   logic [DATA_W-1:0] coreCfg_r;
   logic [ADDR_W-1:0] rrAddr_r;
   logic cont_r;
   logic [DATA_W-1:0] capVal_r;
   logic capValid_r;
   logic [DATA_W-1:0] coreCount_r;
   logic [DATA_W-1:0] scratch_r;
   logic pendValid_r;
   logic pendWr_r;
   logic [ADDR_W-1:0] pendAddr_r;
   logic [DATA_W-1:0] pendData_r;
   logic [DATA_W-1:0] rdData_r;
   logic rdValid_r;
   logic syncDone_r;
   logic [DATA_W-1:0] rdMux;

   logic coreRise;
   logic engStart;
   logic engDone;
   logic engFree;
   logic useP;
   logic reqWr;
   logic reqRd;
   logic [ADDR_W-1:0] reqAddr;
   logic [DATA_W-1:0] reqData;
   logic isCoreWr;
   logic rsRead;
   logic inWs;
   logic blockWr;
   logic blockRd;
   logic doStall;
   logic doRsync;
   logic doWrite;
   logic doRead;
   logic startW;
   logic contRestart;
   logic wsDone;
   logic swDone;

   // ----------------------------------------
   // core clock sampling and shared delay engine
   // ----------------------------------------
   // core clock is sampled even when it equals the bus clock
   crs_edge_sync u_core_clk (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .asyncIn(genericCoreClk),
      .level(),
      .rise(coreRise)
   );

   // one engine for every core register of the block
   crs_sync_delay #(.EDGES(`CRS_SYNC_CORE_EDGES)) u_delay (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .start(engStart),
      .coreRise(coreRise),
      .done(engDone),
      .running()
   );

   // ----------------------------------------
   // request selection and classification
   // ----------------------------------------
   // a held access replays once the engine is free
   assign engFree = (state_r == ST_IDLE) || (state_r == ST_CONT);
   assign useP = pendValid_r && engFree;
   assign reqWr = useP ? pendWr_r : (!pendValid_r && busWr);
   assign reqRd = useP ? !pendWr_r : (!pendValid_r && busRd);
   assign reqAddr = useP ? pendAddr_r : busAddr;
   assign reqData = useP ? pendData_r : busWrData;

   assign isCoreWr = reqWr && ((reqAddr == `CRS_OFF_CTRL) ||
                     (reqAddr == `CRS_OFF_CFG) || (reqAddr == `CRS_OFF_READ_REQUEST_TRIGGER));
   assign rsRead = reqRd && (reqAddr == `CRS_OFF_CNT);
   assign inWs = (state_r == ST_WSYNC);

   // enable and soft reset syncs also block bus-side writes
   assign blockWr = reqWr && (isCoreWr || (wkind_r == WK_ENABLE) ||
                    (wkind_r == WK_SOFT_RESET_BIT));
   assign blockRd = rsRead || (reqRd && (reqAddr == `CRS_OFF_CFG) &&
                    (wkind_r == WK_CFG));
   assign doStall = inWs && (blockWr || blockRd);

   // read-synced read without a captured value runs its own sync
   assign doRsync = engFree && rsRead && !capValid_r;
   assign doWrite = reqWr && !doStall;
   assign doRead = reqRd && !doStall && !doRsync;

   // core writes start a write sync; trigger or continuous starts a request
   assign startW = doWrite && isCoreWr && ((reqAddr != `CRS_OFF_READ_REQUEST_TRIGGER) ||
                   reqData[`CRS_READ_REQUEST_TRIGGER_TRIG] || reqData[`CRS_READ_REQUEST_TRIGGER_CONT]);
   assign wsDone = engDone && inWs;
   assign swDone = wsDone && (wkind_r == WK_SOFT_RESET_BIT);

   // continuous resync; a new write sync takes precedence
   assign contRestart = engDone && cont_r && !startW &&
      ((state_r == ST_CONT) || (inWs && (wkind_r == WK_READ_REQUEST_TRIGGER)));
   assign engStart = startW || doRsync || contRestart;

   // ----------------------------------------
   // engine state and busy flag
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
      end else if (startW) begin
         state_r <= ST_WSYNC;
      end else if (doRsync) begin
         state_r <= ST_RSYNC;
      end else if (engDone) begin
         case (state_r)
            ST_WSYNC: state_r <= contRestart ? ST_CONT : ST_IDLE;
            ST_CONT: state_r <= contRestart ? ST_CONT : ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // busy rises with a write sync only, never with silent resyncs
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_r <= 1'b0;
      end else if (startW) begin
         busy_r <= 1'b1;
      end else if (wsDone) begin
         busy_r <= 1'b0;
      end
   end

   // kind of the running write sync
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wkind_r <= WK_CFG;
      end else if (startW) begin
         case (reqAddr)
            `CRS_OFF_CTRL: wkind_r <= reqData[`CRS_CTRL_SOFT_RESET_BIT] ?
                                      WK_SOFT_RESET_BIT : WK_ENABLE;
            `CRS_OFF_READ_REQUEST_TRIGGER: wkind_r <= WK_READ_REQUEST_TRIGGER;
            default: wkind_r <= WK_CFG;
         endcase
      end
   end

   // ----------------------------------------
   // control: enable and soft reset
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         enable_r <= 1'b0;
         soft_reset_bit_r <= 1'b0;
         coreEnable_r <= 1'b0;
      end else if (swDone) begin
         enable_r <= 1'b0;
         soft_reset_bit_r <= 1'b0;
         coreEnable_r <= 1'b0;
      end else begin
         if (doWrite && (reqAddr == `CRS_OFF_CTRL)) begin
            enable_r <= reqData[`CRS_CTRL_ENABLE];
            if (reqData[`CRS_CTRL_SOFT_RESET_BIT]) begin
               soft_reset_bit_r <= 1'b1;
            end
         end
         if (wsDone && (wkind_r == WK_ENABLE)) begin
            coreEnable_r <= enable_r;
         end
      end
   end

   // ----------------------------------------
   // core configuration and bus scratch
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgShadow_r <= '0;
         coreCfg_r <= '0;
      end else if (swDone) begin
         cfgShadow_r <= '0;
         coreCfg_r <= '0;
      end else begin
         if (doWrite && (reqAddr == `CRS_OFF_CFG)) begin
            cfgShadow_r <= reqData;
         end
         if (wsDone && (wkind_r == WK_CFG)) begin
            coreCfg_r <= cfgShadow_r;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         scratch_r <= '0;
      end else if (swDone) begin
         scratch_r <= '0;
      end else if (doWrite && (reqAddr == `CRS_OFF_SCRATCH)) begin
         scratch_r <= reqData;
      end
   end

   // ----------------------------------------
   // core counter, the read-synchronized value
   // ----------------------------------------
   // advances only on core rises, so resyncs pause with the clock
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         coreCount_r <= '0;
      end else if (swDone) begin
         coreCount_r <= '0;
      end else if (coreRise) begin
         coreCount_r <= coreCount_r + DATA_W'(1);
      end
   end

   // ----------------------------------------
   // read request: address, continuous mode, capture
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rrAddr_r <= '0;
         cont_r <= 1'b0;
      end else if (swDone) begin
         rrAddr_r <= '0;
         cont_r <= 1'b0;
      end else if (doWrite && (reqAddr == `CRS_OFF_READ_REQUEST_TRIGGER)) begin
         rrAddr_r <= reqData[`CRS_READ_REQUEST_TRIGGER_ADDR_HI:0];
         cont_r <= reqData[`CRS_READ_REQUEST_TRIGGER_CONT];
      end else if (startW) begin
         cont_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         capVal_r <= '0;
         capValid_r <= 1'b0;
      end else if (swDone || startW) begin
         // a new sync wins over a resync capture in the same cycle
         capValid_r <= 1'b0;
      end else if ((wsDone && (wkind_r == WK_READ_REQUEST_TRIGGER)) ||
                   (engDone && (state_r == ST_CONT))) begin
         capVal_r <= coreCount_r;
         capValid_r <= (rrAddr_r == `CRS_OFF_CNT);
      end
   end

   // ----------------------------------------
   // held access and wait state
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pendValid_r <= 1'b0;
         pendWr_r <= 1'b0;
         pendAddr_r <= '0;
         pendData_r <= '0;
      end else if (doStall || (doRsync && !useP)) begin
         pendValid_r <= 1'b1;
         pendWr_r <= reqWr;
         pendAddr_r <= reqAddr;
         pendData_r <= reqData;
      end else if ((useP && !doRsync) ||
                   (engDone && (state_r == ST_RSYNC))) begin
         pendValid_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb begin
      rdMux = '0;
      case (reqAddr)
         `CRS_OFF_CTRL: begin
            rdMux[`CRS_CTRL_ENABLE] = enable_r;
            rdMux[`CRS_CTRL_SOFT_RESET_BIT] = soft_reset_bit_r;
         end
         `CRS_OFF_STATUS: rdMux[`CRS_STAT_BUSY] = busy_r;
         `CRS_OFF_READ_REQUEST_TRIGGER: begin
            rdMux[`CRS_READ_REQUEST_TRIGGER_ADDR_HI:0] = rrAddr_r;
            rdMux[`CRS_READ_REQUEST_TRIGGER_CONT] = cont_r;
         end
         `CRS_OFF_CFG: rdMux = coreCfg_r;
         `CRS_OFF_CNT: rdMux = capVal_r;
         `CRS_OFF_SCRATCH: rdMux = scratch_r;
         default: rdMux = '0;
      endcase
   end

   // plain reads answer next cycle; synced reads answer the cycle after engine done
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData_r <= '0;
         rdValid_r <= 1'b0;
      end else if (engDone && (state_r == ST_RSYNC)) begin
         rdData_r <= coreCount_r;
         rdValid_r <= 1'b1;
      end else begin
         rdData_r <= doRead ? rdMux : '0;
         rdValid_r <= doRead;
      end
   end

   // completion event for ordinary syncs only
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncDone_r <= 1'b0;
      end else begin
         syncDone_r <= wsDone && (wkind_r != WK_ENABLE) &&
                       (wkind_r != WK_SOFT_RESET_BIT);
      end
   end

   assign busRdData = rdData_r;
   assign busRdValid = rdValid_r;
   assign busStall = pendValid_r;
   assign coreEnable = coreEnable_r;
   assign coreCfg = coreCfg_r;
   assign syncDone = syncDone_r;
   assign syncState = state_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [3:0] riseSince_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         riseSince_r <= '0;
      end else if (engStart) begin
         riseSince_r <= '0;
      end else if (coreRise && (riseSince_r != 4'hf)) begin
         riseSince_r <= riseSince_r + 4'h1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   chk_busy_on_write: assert property (startW |=> busy_r)
      else $error("busy not raised by write sync");
   chk_core_wr_stall: assert property (
      (inWs && !pendValid_r && busWr && isCoreWr) |=> busStall)
      else $error("core write not stalled");
   chk_rsync_no_busy: assert property (
      (state_r == ST_RSYNC) |-> !busy_r)
      else $error("read sync raised busy");
   chk_plain_read: assert property (doRead |=> busRdValid)
      else $error("plain read not answered next cycle");
   chk_sync_edges: assert property (
      engDone |-> (riseSince_r == 4'h6))
      else $error("sync done after wrong edge count");
   chk_enable_back: assert property (
      (doWrite && (reqAddr == `CRS_OFF_CTRL)) |=>
      (enable_r == $past(reqData[`CRS_CTRL_ENABLE])))
      else $error("enable not read back at once");
   chk_soft_reset_bit_clear: assert property (swDone |=> (!soft_reset_bit_r && !busy_r))
      else $error("soft reset bit or busy not cleared");
   chk_cont_quiet: assert property (
      ((state_r == ST_CONT) && contRestart) |=> !busy_r)
      else $error("busy set by continuous resync");
   chk_cont_stop: assert property (
      (startW && (reqAddr != `CRS_OFF_READ_REQUEST_TRIGGER)) |=> !cont_r)
      else $error("continuous read not stopped");
   chk_done_excl: assert property (
      (wsDone && ((wkind_r == WK_ENABLE) || (wkind_r == WK_SOFT_RESET_BIT)))
      |=> !syncDone)
      else $error("done event for enable or reset");
   chk_bus_rd_free: assert property (
      (inWs && !pendValid_r && busRd && (busAddr == `CRS_OFF_SCRATCH))
      |=> (busRdValid && !busStall))
      else $error("bus register read stalled");

   cov_write_sync: cover property (startW ##[1:200] wsDone);
   cov_read_sync: cover property (doRsync ##[1:200] busRdValid);
   cov_cont_mode: cover property ((state_r == ST_CONT) ##1 contRestart);
endmodule

// >>> verification/crs_cpu_model.sv
// bus master model standing in for the cpu on the register port
module crs_cpu_model (
   input wire logic ref_clk,
   output logic [7:0] busAddr,
   output logic [31:0] busWrData,
   output logic busWr,
   output logic busRd,
   input wire logic [31:0] busRdData,
   input wire logic busRdValid,
   input wire logic busStall
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus at time zero
   initial begin
      busAddr = 8'h00;
      busWrData = 32'h0;
      busWr = 1'b0;
      busRd = 1'b0;
   end

   // one bus cycle; reads see the values sampled at this edge
   task automatic tick();
      @(posedge ref_clk);
   endtask

   // write, then wait out any stall; cyc counts bus cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         output int cyc);
      while (busStall !== 1'b0) tick();
      busAddr <= a;
      busWrData <= d;
      busWr <= 1'b1;
      tick();
      busWr <= 1'b0;
      busAddr <= ~a;
      busWrData <= ~d;
      cyc = 1;
      tick();
      while (busStall === 1'b1 && cyc < 2000) begin
         tick();
         cyc++;
      end
   endtask

   // read; cyc is strobe edge to data edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output int cyc);
      while (busStall !== 1'b0) tick();
      busAddr <= a;
      busRd <= 1'b1;
      tick();
      busRd <= 1'b0;
      busAddr <= ~a;
      cyc = 0;
      while (busRdValid !== 1'b1 && cyc < 2000) begin
         tick();
         cyc++;
      end
      d = busRdData;
   endtask
endmodule

// >>> verification/crs_top_test.sv
// self-checking bench for the common register synchronizer
`include "crs_regs.svh"
module crs_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import crs_pkg::*;

   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic genericCoreClk = 1'b0;
   logic coreRun = 1'b1;
   logic [7:0] busAddr;
   logic [31:0] busWrData;
   logic busWr;
   logic busRd;
   logic [31:0] busRdData;
   logic busRdValid;
   logic busStall;
   logic coreEnable;
   logic [31:0] coreCfg;
   logic syncDone;
   crs_state_t syncState;
   int failCount = 0;
   int checks = 0;
   int doneCnt = 0;

   // bus clock 4 ns, core clock 32 ns that can be stopped
   always #2 ref_clk = ~ref_clk;
   always #16 if (coreRun) genericCoreClk = ~genericCoreClk;

   // count completion events
   always @(posedge ref_clk)
      if (syncDone === 1'b1) doneCnt <= doneCnt + 1;

   crs_cpu_model cpu (.ref_clk(ref_clk), .busAddr(busAddr),
      .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
      .busRdData(busRdData), .busRdValid(busRdValid), .busStall(busStall));

   crs_top #(.DATA_W(32), .ADDR_W(8)) dut (.ref_clk(ref_clk),
      .arst_n(arst_n), .genericCoreClk(genericCoreClk), .busAddr(busAddr),
      .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
      .busRdData(busRdData), .busRdValid(busRdValid), .busStall(busStall),
      .coreEnable(coreEnable), .coreCfg(coreCfg), .syncDone(syncDone),
      .syncState(syncState));

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failCount++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // poll busy until clear
   task automatic wait_idle();
      logic [31:0] v;
      int c;
      int n;
      v = 32'h80;
      n = 0;
      while (v[`CRS_STAT_BUSY] !== 1'b0 && n < 100) begin
         cpu.rd(`CRS_OFF_STATUS, v, c);
         n++;
      end
   endtask

   task automatic t_basic();
      logic [31:0] v;
      int c;
      cpu.rd(`CRS_OFF_STATUS, v, c);
      check(v, 32'h0);
      check(32'(c), 32'h1);
      cpu.rd(8'h1c, v, c);
      check(v, 32'h0);
      cpu.wr(`CRS_OFF_SCRATCH, 32'h1234_abcd, c);
      check(32'(c), 32'h1);
      $display("test basic done");
   endtask

   task automatic t_cfg();
      logic [31:0] v;
      int c;
      int d0;
      d0 = doneCnt;
      cpu.wr(`CRS_OFF_CFG, 32'h5a5a_0001, c);
      cpu.rd(`CRS_OFF_STATUS, v, c);
      check(v, 32'h80);
      cpu.rd(`CRS_OFF_SCRATCH, v, c);
      check(v, 32'h1234_abcd);
      check(32'(c), 32'h1);
      cpu.rd(`CRS_OFF_CFG, v, c);
      check(32'(c > 1), 32'h1);
      check(v, 32'h5a5a_0001);
      check(coreCfg, 32'h5a5a_0001);
      check(32'(doneCnt - d0), 32'h1);
      cpu.rd(`CRS_OFF_CFG, v, c);
      check(32'(c), 32'h1);
      $display("test cfg done");
   endtask

   task automatic t_cnt();
      logic [31:0] a;
      logic [31:0] b;
      int c;
      cpu.wr(`CRS_OFF_CFG, 32'h77, c);
      cpu.rd(`CRS_OFF_CNT, a, c);
      check(32'(c > 80), 32'h1);
      cpu.rd(`CRS_OFF_CNT, b, c);
      check(32'(c * 4 > 168 && c * 4 < 204), 32'h1);
      check(32'(b > a), 32'h1);
      cpu.rd(`CRS_OFF_STATUS, a, c);
      check(a, 32'h0);
      $display("test cnt done");
   endtask

   task automatic t_enable();
      logic [31:0] v;
      int c;
      int d0;
      d0 = doneCnt;
      cpu.wr(`CRS_OFF_CTRL, 32'h2, c);
      cpu.rd(`CRS_OFF_CTRL, v, c);
      check(v, 32'h2);
      check(32'(c), 32'h1);
      cpu.rd(`CRS_OFF_STATUS, v, c);
      check(v, 32'h80);
      cpu.wr(`CRS_OFF_SCRATCH, 32'h55, c);
      check(32'(c > 1), 32'h1);
      check(32'(coreEnable), 32'h1);
      check(32'(doneCnt - d0), 32'h0);
      $display("test enable done");
   endtask

   task automatic t_softrst();
      logic [31:0] v;
      int c;
      int d0;
      d0 = doneCnt;
      cpu.wr(`CRS_OFF_CTRL, 32'h1, c);
      cpu.rd(`CRS_OFF_CTRL, v, c);
      check(32'(v[0]), 32'h1);
      cpu.rd(`CRS_OFF_SCRATCH, v, c);
      check(32'(c), 32'h1);
      cpu.rd(`CRS_OFF_CNT, v, c);
      check(32'(c > 80), 32'h1);
      check(32'(doneCnt - d0), 32'h0);
      cpu.rd(`CRS_OFF_CTRL, v, c);
      check(v, 32'h0);
      check(coreCfg, 32'h0);
      $display("test soft reset done");
   endtask

   task automatic t_req();
      logic [31:0] a;
      logic [31:0] b;
      int c;
      cpu.wr(8'h08, 32'h8010, c);
      cpu.rd(`CRS_OFF_STATUS, a, c);
      check(a, 32'h80);
      wait_idle();
      cpu.rd(`CRS_OFF_CNT, a, c);
      check(32'(c), 32'h1);
      repeat (40) cpu.tick();
      cpu.rd(`CRS_OFF_CNT, b, c);
      check(b, a);
      $display("test request done");
   endtask

   task automatic t_cont();
      logic [31:0] a;
      logic [31:0] b;
      int c;
      cpu.wr(8'h08, 32'h4010, c);
      cpu.rd(`CRS_OFF_STATUS, a, c);
      check(a, 32'h80);
      wait_idle();
      check(32'(syncState), 32'(ST_CONT));
      cpu.rd(`CRS_OFF_CNT, a, c);
      check(32'(c), 32'h1);
      repeat (100) cpu.tick();
      cpu.rd(`CRS_OFF_CNT, b, c);
      check(32'(b > a), 32'h1);
      cpu.rd(`CRS_OFF_STATUS, a, c);
      check(a, 32'h0);
      coreRun = 1'b0;
      repeat (60) cpu.tick();
      cpu.rd(`CRS_OFF_CNT, a, c);
      repeat (60) cpu.tick();
      cpu.rd(`CRS_OFF_CNT, b, c);
      check(b, a);
      coreRun = 1'b1;
      cpu.wr(`CRS_OFF_CFG, 32'h3, c);
      check(32'(syncState), 32'(ST_WSYNC));
      wait_idle();
      cpu.rd(`CRS_OFF_CNT, a, c);
      check(32'(c > 1), 32'h1);
      $display("test continuous done");
   endtask

   // print counts and verdict, end the run
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", checks, failCount);
      if (failCount == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      cpu.tick();
      t_basic();
      t_cfg();
      t_cnt();
      t_enable();
      t_softrst();
      t_req();
      t_cont();
      close_out();
   end

   // cut a hang short
   initial begin
      #200000;
      failCount++;
      close_out();
   end
endmodule
